// ==== verilog/wakeup_status_irq_logic.sv ====
// wake-up, key debounce, event status and interrupt logic with serial port
`timescale 1ns/1ps
module wakeup_status_irq_logic
  import wake_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_PERIODS
)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // serial link
  input  wire logic                 spi_clk,
  input  wire logic                 spi_cs,
  input  wire logic                 serial_in,
  output logic                      serial_out,
  output logic                      serial_out_oe,
  // wake and supply pins
  input  wire logic [KEY_COUNT-1:0] key_input_pin,
  input  wire logic                 wake_pin,
  input  wire logic                 aux_supply_pin,
  input  wire logic                 supply_low,
  input  wire logic                 supply_high,
  input  wire logic                 core_ready,
  // control register bits held outside
  input  wire logic                 supply_out_req,
  input  wire logic                 clk_out_req,
  // buffer side
  input  wire logic [7:0]           buf_count,
  input  wire logic [7:0]           buf_rd_data,
  output logic                      buf_rd_pulse,
  output logic                      buf_wr_pulse,
  output logic [7:0]                buf_wr_data,
  // control register writes
  output logic                      ctrl_wr_pulse,
  output logic [4:0]                ctrl_wr_addr,
  output logic [7:0]                ctrl_wr_data,
  // power and interrupt outputs
  output logic                      irq,
  output logic                      supply_out_enable,
  output logic                      clk_out_enable,
  output logic                      supply_enable,
  output logic                      host_reset_n,
  output logic                      off_mode
);

  typedef enum logic [2:0] {PH_CMD, PH_RDBUF, PH_WRBUF, PH_RDREG, PH_WRREG, PH_IGNORE} phase_e;

  localparam int SYNC_W = KEY_COUNT + 6;
  localparam int DB_W   = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [7:0]      WD_LAST = 8'(WAKE_DELAY_CYC - 1);
  localparam logic [7:0]      WH_LAST = 8'(WAKE_HOLD_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic              rst_s1_r;
  logic              rst_s2_r;
  logic [SYNC_W-1:0] in_s1_r;
  logic [SYNC_W-1:0] in_s2_r;
  logic [2:0]        tgl_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire srst_n = rst_s2_r;

  serial_xfer_if xfer ();

  // keys idle high, so the synchronisers start at one there
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      in_s1_r <= {{KEY_COUNT{1'b1}}, 6'h00};
      in_s2_r <= {{KEY_COUNT{1'b1}}, 6'h00};
      tgl_r   <= 3'h0;
    end
    else
    begin
      in_s1_r <= {key_input_pin, wake_pin, aux_supply_pin, supply_low, supply_high,
                  core_ready, spi_cs};
      in_s2_r <= in_s1_r;
      tgl_r   <= {tgl_r[1:0], xfer.byte_tgl};
    end
  end

  wire [KEY_COUNT-1:0] key_s   = in_s2_r[SYNC_W-1:6];
  wire                 wake_s  = in_s2_r[5];
  wire                 aux_s   = in_s2_r[4];
  wire                 low_s   = in_s2_r[3];
  wire                 high_s  = in_s2_r[2];
  wire                 ready_s = in_s2_r[1];
  wire                 cs_s    = in_s2_r[0];
  wire                 byte_ev = tgl_r[1] ^ tgl_r[2];

  serial_link u_link (
    .spi_clk    (spi_clk),
    .spi_cs     (spi_cs),
    .serial_in  (serial_in),
    .serial_out (serial_out),
    .xfer       (xfer.link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [KEY_COUNT-1:0] key_q_r;
  logic                 wake_q_r;
  logic                 aux_q_r;
  logic [KEY_COUNT-1:0] key_stat_r;
  logic                 pon_r;
  logic                 lb_r;
  logic                 aux_r;
  logic                 irq_r;
  logic                 db_run_r;
  logic [DB_W-1:0]      db_cnt_r;
  logic [KEY_COUNT-1:0] db_sel_r;
  logic                 wd_run_r;
  logic [7:0]           wd_cnt_r;
  logic                 off_r;
  logic [7:0]           hold_cnt_r;
  logic                 wake_pend_r;
  phase_e               ph_r;
  logic [4:0]           addr_r;
  logic [7:0]           tx_r;

  ////////////////////////////////////////////////////////////////////////////
  // debounce decode
  wire [KEY_COUNT-1:0] key_edge = (key_s ^ key_q_r) & {KEY_COUNT{~off_r}};
  wire any_edge  = |key_edge;
  wire db_start  = any_edge && (!db_run_r || |(key_edge & ~db_sel_r));
  wire db_stop   = db_run_r && any_edge && !db_start;
  wire db_done   = db_run_r && !any_edge && (db_cnt_r == DB_LAST);

  // wake pin and aux supply events in active modes
  wire wake_rise = wake_s && !wake_q_r && !off_r;
  wire wd_done   = wd_run_r && (wd_cnt_r == WD_LAST);
  wire aux_rise  = aux_s && !aux_q_r && !off_r;

  // leaving off mode once a wake source holds long enough
  wire wake_cond = (|(~key_s)) || wake_s || aux_s;
  wire off_exit  = off_r && wake_cond && (hold_cnt_r == WH_LAST);
  wire apply     = wake_pend_r && ready_s && !off_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial command decode
  wire [2:0] cmd_type  = xfer.rx_byte[7:5];
  wire [4:0] cmd_addr  = xfer.rx_byte[4:0];
  wire       cmd_ev    = byte_ev && cs_s && (ph_r == PH_CMD);
  wire       rdreg_ev  = byte_ev && cs_s && (ph_r == PH_RDREG);
  wire [4:0] rd_addr   = cmd_ev ? cmd_addr : addr_r;
  wire       stat_rd   = ((cmd_ev && cmd_type == CMD_RD_REG) || rdreg_ev)
                         && (rd_addr == STATUS_ADDR);
  wire       del_irq   = cmd_ev && (cmd_type == CMD_DEL_IRQ);
  wire       off_cmd   = cmd_ev && (cmd_type == CMD_OFF) && !wake_s && (&key_s);
  wire [7:0] status_w  = {key_stat_r, pon_r, lb_r, aux_r};
  wire [7:0] rd_value  = (rd_addr == STATUS_ADDR) ? status_w : UNMAPPED_VALUE;

  ////////////////////////////////////////////////////////////////////////////
  // flag next values; a set in the clearing cycle wins
  wire pon_set = wd_done || (apply && wake_s);
  wire aux_set = aux_rise || (apply && aux_s);
  wire key_upd = db_done || apply;
  wire key_irq = db_done || (apply && |(~key_s));
  wire irq_set = key_irq || (pon_set && !pon_r) || (aux_set && !aux_r);
  wire pon_nxt = pon_set || (pon_r && !stat_rd);
  wire aux_nxt = aux_set || (aux_r && !stat_rd);
  wire lb_nxt  = low_s || (lb_r && !(stat_rd && high_s));
  wire irq_nxt = irq_set || (irq_r && !(stat_rd || del_irq));

  ////////////////////////////////////////////////////////////////////////////
  // edge memory and status flags
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      key_q_r    <= {KEY_COUNT{1'b1}};
      wake_q_r   <= 1'b0;
      aux_q_r    <= 1'b0;
      key_stat_r <= STATUS_RESET[7:KEY_LSB];
      pon_r      <= STATUS_RESET[POWER_ON_BIT];
      lb_r       <= STATUS_RESET[LOW_BATT_BIT];
      aux_r      <= STATUS_RESET[AUX_BIT];
      irq_r      <= 1'b0;
    end
    else
    begin
      key_q_r  <= key_s;
      wake_q_r <= wake_s;
      aux_q_r  <= aux_s;
      if (key_upd)
        key_stat_r <= ~key_s;
      pon_r <= pon_nxt;
      lb_r  <= lb_nxt;
      aux_r <= aux_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key debounce counter
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      db_run_r <= 1'b0;
      db_cnt_r <= '0;
      db_sel_r <= '0;
    end
    else if (db_start)
    begin
      db_run_r <= 1'b1;
      db_cnt_r <= '0;
      db_sel_r <= key_edge;
    end
    else if (db_stop || db_done || off_r)
      db_run_r <= 1'b0;
    else if (db_run_r)
      db_cnt_r <= db_cnt_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake pin delay; a second rise while waiting restarts it
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      wd_run_r <= 1'b0;
      wd_cnt_r <= 8'h00;
    end
    else if (wake_rise)
    begin
      wd_run_r <= 1'b1;
      wd_cnt_r <= 8'h00;
    end
    else if (wd_done || off_r)
      wd_run_r <= 1'b0;
    else if (wd_run_r)
      wd_cnt_r <= wd_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // off mode and wake-up from it
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      off_r       <= 1'b0;
      hold_cnt_r  <= 8'h00;
      wake_pend_r <= 1'b0;
    end
    else
    begin
      if (off_cmd)
        off_r <= 1'b1;
      else if (off_exit)
        off_r <= 1'b0;
      if (!off_r || !wake_cond || off_exit)
        hold_cnt_r <= 8'h00;
      else
        hold_cnt_r <= hold_cnt_r + 8'h01;
      if (off_exit)
        wake_pend_r <= 1'b1;
      else if (apply)
        wake_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial transaction sequencing
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      ph_r   <= PH_CMD;
      addr_r <= 5'h00;
      tx_r   <= 8'h00;
    end
    else if (!cs_s)
    begin
      ph_r <= PH_CMD;
      tx_r <= buf_count;
    end
    else if (cmd_ev)
    begin
      addr_r <= cmd_addr + 5'h01;
      unique case (cmd_type)
        CMD_RD_BUF:
        begin
          ph_r <= PH_RDBUF;
          tx_r <= buf_rd_data;
        end
        CMD_WR_BUF:
        begin
          ph_r <= PH_WRBUF;
          tx_r <= xfer.rx_byte;
        end
        CMD_RD_REG:
        begin
          ph_r <= PH_RDREG;
          tx_r <= rd_value;
        end
        CMD_WR_REG:
        begin
          ph_r   <= PH_WRREG;
          addr_r <= cmd_addr;
          tx_r   <= xfer.rx_byte;
        end
        default:
          ph_r <= PH_IGNORE;
      endcase
    end
    else if (byte_ev)
    begin
      unique case (ph_r)
        PH_RDBUF:  tx_r <= buf_rd_data;
        PH_WRBUF:  tx_r <= xfer.rx_byte;
        PH_RDREG:
        begin
          tx_r   <= rd_value;
          addr_r <= addr_r + 5'h01;
        end
        PH_WRREG:
        begin
          tx_r   <= xfer.rx_byte;
          addr_r <= addr_r + 5'h01;
        end
        default:   tx_r <= tx_r;
      endcase
    end
  end

  assign xfer.tx_byte = tx_r;

  ////////////////////////////////////////////////////////////////////////////
  // buffer and control register strobes
  wire data_ev = byte_ev && cs_s;

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      buf_rd_pulse  <= 1'b0;
      buf_wr_pulse  <= 1'b0;
      buf_wr_data   <= 8'h00;
      ctrl_wr_pulse <= 1'b0;
      ctrl_wr_addr  <= 5'h00;
      ctrl_wr_data  <= 8'h00;
    end
    else
    begin
      buf_rd_pulse  <= (cmd_ev && cmd_type == CMD_RD_BUF) || (data_ev && ph_r == PH_RDBUF);
      buf_wr_pulse  <= data_ev && (ph_r == PH_WRBUF);
      ctrl_wr_pulse <= data_ev && (ph_r == PH_WRREG);
      if (data_ev && ph_r != PH_CMD)
      begin
        buf_wr_data  <= xfer.rx_byte;
        ctrl_wr_data <= xfer.rx_byte;
        ctrl_wr_addr <= addr_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power outputs; clock and reset wait until supply and oscillator are good
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      irq               <= 1'b0;
      supply_out_enable <= 1'b1;
      clk_out_enable    <= 1'b0;
      supply_enable     <= 1'b1;
      host_reset_n      <= 1'b0;
      off_mode          <= 1'b0;
      serial_out_oe     <= 1'b0;
    end
    else
    begin
      irq               <= irq_r;
      supply_out_enable <= !off_r && (supply_out_req || pon_r || db_run_r);
      clk_out_enable    <= !off_r && ready_s && (clk_out_req || pon_r || db_run_r);
      supply_enable     <= !off_r;
      host_reset_n      <= !off_r && ready_s && !wake_pend_r;
      off_mode          <= off_r;
      serial_out_oe     <= cs_s;
    end
  end

endmodule : wakeup_status_irq_logic

// ==== verilog/wake_pkg.sv ====
// constants shared by the wake-up and status logic
package wake_pkg;

  // status register address and bit layout
  localparam logic [4:0] STATUS_ADDR    = 5'h08;
  localparam int         KEY_COUNT      = 5;
  localparam int         AUX_BIT        = 0;
  localparam int         LOW_BATT_BIT   = 1;
  localparam int         POWER_ON_BIT   = 2;
  localparam int         KEY_LSB        = 3;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // command type, top three bits of the command byte
  localparam logic [2:0] CMD_RD_BUF  = 3'h0;
  localparam logic [2:0] CMD_WR_BUF  = 3'h1;
  localparam logic [2:0] CMD_RD_REG  = 3'h2;
  localparam logic [2:0] CMD_WR_REG  = 3'h3;
  localparam logic [2:0] CMD_OFF     = 3'h4;
  localparam logic [2:0] CMD_DEL_IRQ = 3'h5;

  // timing, digital clock is sys_clk
  localparam int CLK_PERIOD_NS    = 40;
  localparam int DEBOUNCE_PERIODS = 8195;
  localparam int WAKE_DELAY_NS    = 160;
  localparam int WAKE_DELAY_CYC   = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_HOLD_NS     = 1000;
  localparam int WAKE_HOLD_CYC    = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : wake_pkg

// ==== verilog/serial_xfer_if.sv ====
// byte hand-over between the serial link and the core logic
`timescale 1ns/1ps
interface serial_xfer_if;
  logic [7:0] rx_byte;
  logic       byte_tgl;
  logic [7:0] tx_byte;

  modport link (output rx_byte, output byte_tgl, input tx_byte);
  modport core (input rx_byte, input byte_tgl, output tx_byte);
endinterface : serial_xfer_if

// ==== verilog/serial_link.sv ====
// serial shift engine clocked by the host's serial clock
`timescale 1ns/1ps
module serial_link
  import wake_pkg::*;
(
  // link pins
  input  wire logic spi_clk,
  input  wire logic spi_cs,
  input  wire logic serial_in,
  output logic      serial_out,
  // towards the core
  serial_xfer_if.link xfer
);

  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic       tgl_r;
  logic [7:0] tx_sh_r;
  logic       loaded_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive, msb first; chip select low holds everything in reset
  always_ff @(posedge spi_clk or negedge spi_cs)
  begin
    if (!spi_cs)
    begin
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 7'h00;
      rx_byte_r <= 8'h00;
      tgl_r     <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r   <= {rx_sh_r[5:0], serial_in};
      if (bit_cnt_r == 3'h7)
      begin
        rx_byte_r <= {rx_sh_r, serial_in};
        tgl_r     <= ~tgl_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit on the falling edge; tx_byte is held still by the core
  // around byte boundaries, so it is sampled here without a synchroniser
  always_ff @(negedge spi_clk or negedge spi_cs)
  begin
    if (!spi_cs)
    begin
      tx_sh_r  <= 8'h00;
      loaded_r <= 1'b0;
    end
    else
    begin
      loaded_r <= 1'b1;
      if (!loaded_r)
        tx_sh_r <= {xfer.tx_byte[6:0], 1'b0};
      else if (bit_cnt_r == 3'h0)
        tx_sh_r <= xfer.tx_byte;
      else
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  // first bit must be out before any clock edge arrives
  assign serial_out    = loaded_r ? tx_sh_r[7] : xfer.tx_byte[7];
  assign xfer.rx_byte  = rx_byte_r;
  assign xfer.byte_tgl = tgl_r;

endmodule : serial_link

// ==== testbench/wake_sva.sv ====
// port-level checks of the wake-up, status and interrupt block
`timescale 1ns/1ps
module wake_sva
  import wake_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // watched pins
  input wire logic                 spi_cs,
  input wire logic [KEY_COUNT-1:0] key_input_pin,
  input wire logic                 wake_pin,
  input wire logic                 core_ready,
  input wire logic                 serial_out_oe,
  input wire logic                 buf_rd_pulse,
  input wire logic                 buf_wr_pulse,
  input wire logic                 ctrl_wr_pulse,
  input wire logic                 irq,
  input wire logic                 supply_out_enable,
  input wire logic                 clk_out_enable,
  input wire logic                 host_reset_n,
  input wire logic                 off_mode
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_oe_released: assert property (!spi_cs [*4] |-> !serial_out_oe)
    else $error("serial output enabled while deselected");
  a_oe_driven: assert property (spi_cs [*4] |-> serial_out_oe)
    else $error("serial output not enabled while selected");
  // no link activity means nothing may clear the level
  a_irq_level: assert property ((irq && !spi_cs && !$past(spi_cs) && !$past(spi_cs, 2))
    |=> irq)
    else $error("interrupt dropped with no host action");
  a_key_forces_en: assert property (((key_input_pin != $past(key_input_pin)) && !off_mode)
    |-> ##[1:6] (supply_out_enable && clk_out_enable))
    else $error("enables not forced by running debounce");
  a_wake_forces_en: assert property (($rose(wake_pin) && !off_mode)
    |-> ##[3:10] (supply_out_enable && clk_out_enable))
    else $error("enables not forced after wake pin rise");
  a_reset_waits: assert property ($rose(host_reset_n) |-> $past(core_ready, 3))
    else $error("host reset released before core ready");
  a_wr_single: assert property (buf_wr_pulse |=> !buf_wr_pulse)
    else $error("buffer write strobe longer than one cycle");
  a_rd_single: assert property (buf_rd_pulse |=> !buf_rd_pulse)
    else $error("buffer read strobe longer than one cycle");
  a_ctrl_single: assert property (ctrl_wr_pulse |=> !ctrl_wr_pulse)
    else $error("control write strobe longer than one cycle");
endmodule : wake_sva

// ==== testbench/host_model.sv ====
// host side of the serial link: frames and msb-first bytes
`timescale 1ns/1ps
module host_model
(
  // link pins
  output logic      spi_clk,
  output logic      spi_cs,
  output logic      serial_in,
  input  wire logic serial_out
);
  initial
  begin
    spi_clk   = 1'b0;
    spi_cs    = 1'b0;
    serial_in = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // settle time lets the count byte load before the first edge
  task automatic frame_on;
    spi_cs = 1'b1;
    #300;
  endtask : frame_on
  // long high phase after the eighth edge, the byte must cross domains
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = tx[i];
      #7.5;
      spi_clk = 1'b1;
      rx[i] = serial_out;
      #((i == 0) ? 320 : 7.5);
      spi_clk = 1'b0;
    end
  endtask : xfer
  // released data line shows the inverse of its last level
  task automatic frame_off;
    #20;
    spi_cs    = 1'b0;
    serial_in = ~serial_in;
    #200;
  endtask : frame_off
endmodule : host_model

// ==== testbench/tb.sv ====
// self-checking bench for the wake-up, status and interrupt block
`timescale 1ns/1ps
module tb;
  import wake_pkg::*;
  localparam int DB = 20;
  logic sys_clk = 1'b0, rst_n, spi_clk, spi_cs, serial_in, serial_out, serial_out_oe;
  logic [KEY_COUNT-1:0] key_input_pin;
  logic wake_pin, aux_supply_pin, supply_low, supply_high, core_ready;
  logic supply_out_req, clk_out_req, buf_rd_pulse, buf_wr_pulse, ctrl_wr_pulse;
  logic [7:0] buf_count, buf_rd_data, buf_wr_data, ctrl_wr_data, r0, r1, r2;
  logic [4:0] ctrl_wr_addr;
  logic irq, supply_out_enable, clk_out_enable, supply_enable, host_reset_n, off_mode;
  int bad_count = 0;
  int cmp_count = 0;
  int rd_pops = 0, wr_pushes = 0, ctrl_writes = 0;
  always #20 sys_clk = ~sys_clk;
  // strobe tallies, taken mid-cycle where the registered strobes are settled
  always @(negedge sys_clk)
  begin
    if (buf_rd_pulse === 1'b1)
      rd_pops++;
    if (buf_wr_pulse === 1'b1)
      wr_pushes++;
    if (ctrl_wr_pulse === 1'b1)
      ctrl_writes++;
  end
  wakeup_status_irq_logic #(.DEBOUNCE_CYCLES(DB)) u_wakeup_status_irq_logic
    (.sys_clk, .rst_n, .spi_clk, .spi_cs, .serial_in, .serial_out, .serial_out_oe,
     .key_input_pin, .wake_pin, .aux_supply_pin, .supply_low, .supply_high, .core_ready,
     .supply_out_req, .clk_out_req, .buf_count, .buf_rd_data, .buf_rd_pulse,
     .buf_wr_pulse, .buf_wr_data, .ctrl_wr_pulse, .ctrl_wr_addr, .ctrl_wr_data, .irq,
     .supply_out_enable, .clk_out_enable, .supply_enable, .host_reset_n, .off_mode);
  host_model u_host_model (.spi_clk, .spi_cs, .serial_in, .serial_out);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bit_is(input string name, input logic seen, input logic exp);
    chk(name, {7'h00, seen}, {7'h00, exp});
  endtask : bit_is
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  // one selection: command byte, then data bytes, count checked each time
  task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] d1,
                       input logic [7:0] d2);
    u_host_model.frame_on();
    u_host_model.xfer(cmd, r0);
    chk("byte count", r0, buf_count);
    if (n > 0)
      u_host_model.xfer(d1, r1);
    if (n > 1)
      u_host_model.xfer(d2, r2);
    u_host_model.frame_off();
  endtask : frame
  task automatic status_is(input string name, input logic [7:0] exp);
    frame({CMD_RD_REG, STATUS_ADDR}, 1, 8'h00, 8'h00);
    chk(name, r1, exp);
  endtask : status_is
  task automatic wait_ready;
    for (int i = 0; i < 60 && host_reset_n !== 1'b1; i++)
      cyc(1);
    bit_is("host reset", host_reset_n, 1'b1);
  endtask : wait_ready
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end
  initial
  begin
    rst_n = 1'b0;
    {key_input_pin, wake_pin, aux_supply_pin, supply_low} = {5'h1f, 3'h0};
    {supply_high, core_ready, supply_out_req, clk_out_req} = 4'hc;
    buf_count = 8'h5a;
    buf_rd_data = 8'h96;
    cyc(3);
    rst_n = 1'b1;
    wait_ready();
    status_is("status reset", STATUS_RESET);
    key_input_pin = 5'h1e;
    cyc(DB + 15);
    bit_is("key irq", irq, 1'b1);
    frame(8'h47, 2, 8'h00, 8'h00);
    chk("unmapped read", r1, UNMAPPED_VALUE);
    chk("next register", r2, 8'h08);
    status_is("key1 status", 8'h08);
    bit_is("irq after read", irq, 1'b0);
    key_input_pin = 5'h1f;
    cyc(5);
    key_input_pin = 5'h1e;
    cyc(DB + 20);
    bit_is("same key stop", irq, 1'b0);
    key_input_pin = 5'h1f;
    cyc(15);
    key_input_pin = 5'h1d;
    cyc(15);
    bit_is("other key restart", irq, 1'b0);
    cyc(25);
    bit_is("restarted end", irq, 1'b1);
    frame({CMD_DEL_IRQ, 5'h00}, 0, 8'h00, 8'h00);
    cyc(2);
    bit_is("delete irq", irq, 1'b0);
    status_is("key2 status", 8'h10);
    key_input_pin = 5'h1f;
    cyc(DB + 15);
    status_is("keys idle", 8'h00);
    done("debounce");
    wake_pin = 1'b1;
    cyc(12);
    bit_is("wake irq", irq, 1'b1);
    bit_is("wake supply en", supply_out_enable, 1'b1);
    bit_is("wake clock en", clk_out_enable, 1'b1);
    status_is("power on flag", 8'h04);
    bit_is("wake irq cleared", irq, 1'b0);
    status_is("power on cleared", 8'h00);
    bit_is("supply en freed", supply_out_enable, 1'b0);
    wake_pin = 1'b0;
    cyc(30);
    bit_is("no off on low", off_mode, 1'b0);
    done("wake pin");
    aux_supply_pin = 1'b1;
    cyc(10);
    bit_is("aux irq", irq, 1'b1);
    status_is("aux flag", 8'h01);
    status_is("aux cleared", 8'h00);
    bit_is("aux no re-raise", irq, 1'b0);
    aux_supply_pin = 1'b0;
    done("aux");
    {supply_low, supply_high} = 2'b10;
    cyc(8);
    status_is("low batt set", 8'h02);
    supply_low = 1'b0;
    cyc(8);
    status_is("low batt held", 8'h02);
    supply_high = 1'b1;
    cyc(8);
    status_is("low batt last", 8'h02);
    status_is("low batt clear", 8'h00);
    done("low battery");
    frame({CMD_WR_BUF, 5'h00}, 2, 8'h3c, 8'hc3);
    chk("echo command", r1, 8'h20);
    chk("echo data", r2, 8'h3c);
    chk("buffer data", buf_wr_data, 8'hc3);
    frame({CMD_RD_BUF, 5'h00}, 1, 8'h00, 8'h00);
    chk("buffer read", r1, 8'h96);
    frame({CMD_WR_REG, 5'h01}, 1, 8'h5a, 8'h00);
    chk("control addr", {3'h0, ctrl_wr_addr}, 8'h01);
    chk("control data", ctrl_wr_data, 8'h5a);
    chk("read pops", 8'(rd_pops), 8'h02);
    chk("write pushes", 8'(wr_pushes), 8'h02);
    chk("control writes", 8'(ctrl_writes), 8'h01);
    done("transfers");
    frame({CMD_OFF, 5'h00}, 0, 8'h00, 8'h00);
    cyc(10);
    bit_is("off entered", off_mode, 1'b1);
    bit_is("off supplies", supply_enable, 1'b0);
    bit_is("off host reset", host_reset_n, 1'b0);
    // oscillator not yet settled: flags and reset release must wait for it
    core_ready = 1'b0;
    key_input_pin = 5'h0f;
    cyc(WAKE_HOLD_CYC + 30);
    bit_is("key wake", off_mode, 1'b0);
    bit_is("wake supplies", supply_enable, 1'b1);
    bit_is("reset waits", host_reset_n, 1'b0);
    bit_is("irq waits", irq, 1'b0);
    core_ready = 1'b1;
    wait_ready();
    bit_is("wake key irq", irq, 1'b1);
    status_is("wake key status", 8'h80);
    key_input_pin = 5'h1f;
    cyc(DB + 15);
    status_is("keys released", 8'h00);
    frame({CMD_OFF, 5'h00}, 0, 8'h00, 8'h00);
    aux_supply_pin = 1'b1;
    cyc(WAKE_HOLD_CYC + 30);
    bit_is("aux wake", off_mode, 1'b0);
    bit_is("aux wake irq", irq, 1'b1);
    status_is("aux wake flag", 8'h01);
    done("off mode");
    conclude();
  end
endmodule : tb
bind wakeup_status_irq_logic wake_sva u_wake_sva
  (.sys_clk, .rst_n, .spi_cs, .key_input_pin, .wake_pin, .core_ready, .serial_out_oe,
   .buf_rd_pulse, .buf_wr_pulse, .ctrl_wr_pulse, .irq, .supply_out_enable,
   .clk_out_enable, .host_reset_n, .off_mode);
